//--- include/dmp_pkg.sv
// Purpose: Constants and types for the dual motor drive protection block.
// Assumes: 125 MHz system clock; 12-bit samples scaled as the converter delivers them.
// Notes:   Thresholds are expressed in converter codes derived from the scale figures.
//
// Operation
// - Both motor channels get identical control and protection behaviour.
// - Phase current magnitude above 3.54 A shuts down that motor's outputs.
// - Bus voltage above 60 V shuts down the affected channel.
// - Bus voltage below 8 V shuts down the affected channel.
// - Rotation speed above 4500 rpm shuts down that channel's gate outputs.
// - Any fault disables all six gate outputs of that channel together.
// - Overcurrent error interrupt has priority level 0 on both channels.
// - Conversion-complete interrupt has priority level 5 on both channels.
// - A 500 us periodic tick interrupt has priority level 10, shared.
// - Channel states stopped, driving, error; only reset leaves error.
package dmp_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ          = 125;
    localparam int CARRIER_US       = 50;
    localparam int DEAD_NS          = 2000;
    localparam int TICK_US          = 500;
    localparam int CARRIER_CYC      = CARRIER_US * CLK_MHZ;
    localparam int HALF_CARRIER_CYC = CARRIER_CYC / 2;
    localparam int DEAD_CYC         = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int TICK_CYC         = TICK_US * CLK_MHZ;

    // ---------------------------------------------------------------
    // Limits in converter codes
    // ---------------------------------------------------------------
    // Current: -8.25 A..8.25 A over 0..4095, midpoint 2048.
    localparam logic [11:0] CUR_MID    = 12'h0800;
    localparam logic [11:0] CUR_LIMIT  = 12'h0370;  // 3.54 A from the midpoint.
    // Bus voltage: 0..73.26 V over 0..4095.
    localparam logic [11:0] VBUS_HIGH  = 12'h0D1B;  // 60 V.
    localparam logic [11:0] VBUS_LOW   = 12'h01BF;  // 8 V.
    localparam logic [15:0] SPEED_LIMIT = 16'h1194; // 4500 rpm.

    // ---------------------------------------------------------------
    // Interrupt priority levels
    // ---------------------------------------------------------------
    localparam logic [3:0] PRIO_OVERCURRENT = 4'h0;
    localparam logic [3:0] PRIO_CONV_DONE   = 4'h5;
    localparam logic [3:0] PRIO_SLOW_TICK   = 4'hA;
    localparam logic [3:0] PRIO_NONE        = 4'hF;

    typedef enum logic [1:0] {
        DMP_DRIVE_STOPPED_STATE,
        DMP_DRIVING,
        DMP_ERROR
    } dmp_state_t;

endpackage : dmp_pkg

//--- logic/dmp_channel.sv
// Purpose: One motor channel: fault checks, state, carrier and dead-time gates.
// Assumes: Samples are valid on the cycle that conv_done pulses.
// Notes:   Six gate outputs with enables; enables low means high impedance.
`timescale 1ns/1ps
module dmp_channel
    import dmp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        run_req,
    input  wire logic        ext_oc_n,
    input  wire logic        conv_done,
    input  wire logic [11:0] cur_u,
    input  wire logic [11:0] cur_v,
    input  wire logic [11:0] cur_w,
    input  wire logic [11:0] vbus,
    input  wire logic [15:0] speed,
    input  wire logic [11:0] duty_u,
    input  wire logic [11:0] duty_v,
    input  wire logic [11:0] duty_w,
    output logic      [5:0]  gate_q,
    output logic      [5:0]  gate_oe_q,
    output logic      [1:0]  state_q,
    output logic      [3:0]  fault_q
);

    // ---------------------------------------------------------------
    // Fault detection
    // ---------------------------------------------------------------
    function automatic logic over_cur(input logic [11:0] s);
        logic [11:0] mag;
        mag = (s >= CUR_MID) ? s - CUR_MID : CUR_MID - s;
        return mag > CUR_LIMIT;
    endfunction : over_cur

    dmp_state_t  st_q, st_d;
    logic [3:0]  flt_q, flt_d;
    logic [3:0]  chk;
    logic [12:0] cnt_q, cnt_d;
    logic        up_q, up_d;
    logic [2:0]  raw;
    logic [2:0]  prev_q, prev_d;
    logic [7:0]  dead_q [3], dead_d [3];
    logic [5:0]  g_d, oe_d;

    always_comb begin
        chk[0] = over_cur(cur_u) | over_cur(cur_v) | over_cur(cur_w);
        chk[1] = vbus > VBUS_HIGH;
        chk[2] = vbus < VBUS_LOW;
        chk[3] = speed > SPEED_LIMIT;
        flt_d  = flt_q;
        st_d   = st_q;
        if (conv_done && (chk != 4'h0)) begin
            flt_d = flt_q | chk;
        end
        case (st_q)
            DMP_DRIVE_STOPPED_STATE: begin
                if (flt_d != 4'h0) st_d = DMP_ERROR;
                else if (run_req) st_d = DMP_DRIVING;
            end
            DMP_DRIVING: begin
                if (flt_d != 4'h0) st_d = DMP_ERROR;
                else if (!run_req) st_d = DMP_DRIVE_STOPPED_STATE;
            end
            DMP_ERROR: st_d = DMP_ERROR;
            default:   st_d = DMP_DRIVE_STOPPED_STATE;
        endcase
    end

    // ---------------------------------------------------------------
    // Carrier and dead time
    // ---------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        up_d  = up_q;
        if (up_q) begin
            if (cnt_q == 13'(HALF_CARRIER_CYC - 1)) up_d = 1'b0;
            else cnt_d = cnt_q + 13'd1;
        end else begin
            if (cnt_q == 13'd0) up_d = 1'b1;
            else cnt_d = cnt_q - 13'd1;
        end
        raw[0] = {1'b0, duty_u} > cnt_q;
        raw[1] = {1'b0, duty_v} > cnt_q;
        raw[2] = {1'b0, duty_w} > cnt_q;
        prev_d = raw;
    end

    // Each phase leg waits out the dead time after any edge before either switch closes.
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_leg
            always_comb begin
                if (raw[p] != prev_q[p]) dead_d[p] = 8'(DEAD_CYC);
                else if (dead_q[p] != 8'h00) dead_d[p] = dead_q[p] - 8'h01;
                else dead_d[p] = 8'h00;
                g_d[2*p]   = (st_d == DMP_DRIVING) && raw[p] && (dead_d[p] == 8'h00);
                g_d[2*p+1] = (st_d == DMP_DRIVING) && !raw[p] && (dead_d[p] == 8'h00);
            end
        end
    endgenerate

    // Hardware overcurrent line drops all drivers without waiting for software.
    always_comb begin
        oe_d = ext_oc_n ? 6'h3F : 6'h00;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q      <= DMP_DRIVE_STOPPED_STATE;
            flt_q     <= 4'h0;
            cnt_q     <= 13'h0000;
            up_q      <= 1'b1;
            prev_q    <= 3'h0;
            dead_q    <= '{default: 8'h00};
            gate_q    <= 6'h00;
            gate_oe_q <= 6'h00;
        end else begin
            st_q      <= st_d;
            flt_q     <= flt_d;
            cnt_q     <= cnt_d;
            up_q      <= up_d;
            prev_q    <= prev_d;
            dead_q    <= dead_d;
            gate_q    <= (flt_d != 4'h0) ? 6'h00 : g_d;
            gate_oe_q <= oe_d;
        end
    end

    assign state_q = st_q;
    assign fault_q = flt_q;

endmodule : dmp_channel

//--- logic/dmp_top.sv
// Purpose: Two identical protected motor channels and interrupt priority ordering.
// Assumes: Pins from outside are synchronised here; samples come from same-clock logic.
// Notes:   The overcurrent request outranks conversion-done, which outranks the slow tick.
`timescale 1ns/1ps
module dmp_top
    import dmp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        motor1_run_switch,
    input  wire logic        motor2_run_switch,
    input  wire logic        ext_oc1_n,
    input  wire logic        ext_oc2_n,
    input  wire logic [1:0]  conv_done,
    input  wire logic [11:0] cur_u [2],
    input  wire logic [11:0] cur_v [2],
    input  wire logic [11:0] cur_w [2],
    input  wire logic [11:0] vbus [2],
    input  wire logic [15:0] speed [2],
    input  wire logic [11:0] duty_u [2],
    input  wire logic [11:0] duty_v [2],
    input  wire logic [11:0] duty_w [2],
    output logic      [5:0]  gate_q [2],
    output logic      [5:0]  gate_oe_q [2],
    output logic      [1:0]  state_q [2],
    output logic      [3:0]  fault_q [2],
    output logic      [1:0]  overcurrent_interrupt_q,
    output logic      [1:0]  conversion_done_interrupt_q,
    output logic             slow_tick_interrupt_q,
    output logic             irq_q,
    output logic      [3:0]  irq_level_q
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    // Three stages; a change is accepted only when stages two and three agree.
    logic [3:0] s1_q, s2_q, s3_q, flt_pin_q, s1_d, s2_d, s3_d, flt_pin_d;
    logic [3:0] pins;

    always_comb begin
        pins      = {ext_oc2_n, ext_oc1_n, motor2_run_switch, motor1_run_switch};
        s1_d      = pins;
        s2_d      = s1_q;
        s3_d      = s2_q;
        flt_pin_d = flt_pin_q;
        for (int i = 0; i < 4; i++) begin
            if (s2_q[i] == s3_q[i]) flt_pin_d[i] = s3_q[i];
        end
    end

    // ---------------------------------------------------------------
    // Channels
    // ---------------------------------------------------------------
    logic [1:0] oc_fall;
    logic [1:0] oc_prev_q;

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            dmp_channel u_ch (
                .clk       (clk),
                .srst      (srst),
                .run_req   (flt_pin_q[c]),
                .ext_oc_n  (flt_pin_q[2+c]),
                .conv_done (conv_done[c]),
                .cur_u     (cur_u[c]),
                .cur_v     (cur_v[c]),
                .cur_w     (cur_w[c]),
                .vbus      (vbus[c]),
                .speed     (speed[c]),
                .duty_u    (duty_u[c]),
                .duty_v    (duty_v[c]),
                .duty_w    (duty_w[c]),
                .gate_q    (gate_q[c]),
                .gate_oe_q (gate_oe_q[c]),
                .state_q   (state_q[c]),
                .fault_q   (fault_q[c])
            );
            assign oc_fall[c] = oc_prev_q[c] && !flt_pin_q[2+c];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Slow tick and priority
    // ---------------------------------------------------------------
    logic [15:0] tick_q, tick_d;
    logic        tick_hit;
    logic [3:0]  lvl_d;

    always_comb begin
        tick_hit = tick_q == 16'(TICK_CYC - 1);
        tick_d   = tick_hit ? 16'h0000 : tick_q + 16'h0001;
        if (oc_fall != 2'b00) lvl_d = PRIO_OVERCURRENT;
        else if (conv_done != 2'b00) lvl_d = PRIO_CONV_DONE;
        else if (tick_hit) lvl_d = PRIO_SLOW_TICK;
        else lvl_d = PRIO_NONE;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // Idle pin levels, so that no false overcurrent edge follows reset.
            s1_q                        <= 4'hC;
            s2_q                        <= 4'hC;
            s3_q                        <= 4'hC;
            flt_pin_q                   <= 4'hC;
            oc_prev_q                   <= 2'b11;
            tick_q                      <= 16'h0000;
            overcurrent_interrupt_q     <= 2'b00;
            conversion_done_interrupt_q <= 2'b00;
            slow_tick_interrupt_q       <= 1'b0;
            irq_q                       <= 1'b0;
            irq_level_q                 <= PRIO_NONE;
        end else begin
            s1_q                        <= s1_d;
            s2_q                        <= s2_d;
            s3_q                        <= s3_d;
            flt_pin_q                   <= flt_pin_d;
            oc_prev_q                   <= flt_pin_q[3:2];
            tick_q                      <= tick_d;
            overcurrent_interrupt_q     <= oc_fall;
            conversion_done_interrupt_q <= conv_done;
            slow_tick_interrupt_q       <= tick_hit;
            irq_q                       <= lvl_d != PRIO_NONE;
            irq_level_q                 <= lvl_d;
        end
    end

endmodule : dmp_top

//--- tb/dmp_top_asserts.sv
// Purpose: Port assertions for the dual motor drive protection block.
// Assumes: Channel 0 carries the assertions; the bench repeats the four fault trips, not the external overcurrent, on channel 1.
// Notes:   Limit codes are written out so that a wrong package constant shows up.
`timescale 1ns/1ps
module dmp_top_asserts (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        ext_oc1_n,
    input wire logic [1:0]  conv_done,
    input wire logic [11:0] cur_u [2],
    input wire logic [11:0] vbus [2],
    input wire logic [15:0] speed [2],
    input wire logic [5:0]  gate_q [2],
    input wire logic [5:0]  gate_oe_q [2],
    input wire logic [1:0]  state_q [2],
    input wire logic [3:0]  fault_q [2],
    input wire logic [1:0]  overcurrent_interrupt_q,
    input wire logic [1:0]  conversion_done_interrupt_q,
    input wire logic        slow_tick_interrupt_q,
    input wire logic        irq_q,
    input wire logic [3:0]  irq_level_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // The pin passes a synchroniser and a filter, so at least five low cycles are needed.
    sequence oc_held; !ext_oc1_n [*6]; endsequence
    sequence tripped(int b); fault_q[0][b] && state_q[0] == 2'd2 && gate_q[0] == 6'h00; endsequence
    // Two high samples then two low ones give a clean filtered falling edge.
    sequence oc_drop; ext_oc1_n [*2] ##1 !ext_oc1_n [*2]; endsequence
    // Reset counts as a long off time, so the first turn-on after reset does not fire.
    logic [7:0]  hi_off_q;
    logic [15:0] tick_gap_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            hi_off_q   <= 8'hFF;
            tick_gap_q <= 16'h0000;
        end else begin
            hi_off_q   <= gate_q[0][0] ? 8'h00 : hi_off_q + {7'h00, hi_off_q != 8'hFF};
            tick_gap_q <= slow_tick_interrupt_q ? 16'h0001 : tick_gap_q + 16'h0001;
        end
    end
    a_cur_trip: assert property (conv_done[0] && cur_u[0] > 12'h0B70 |=> tripped(0))
        else $error("phase current trip missed");
    a_over_volt: assert property (conv_done[0] && vbus[0] > 12'h0D1B |=> tripped(1))
        else $error("overvoltage trip missed");
    a_under_volt: assert property (conv_done[0] && vbus[0] < 12'h01BF |=> tripped(2))
        else $error("undervoltage trip missed");
    a_over_speed: assert property (conv_done[0] && speed[0] > 16'h1194 |=> tripped(3))
        else $error("overspeed trip missed");
    a_error_sticky: assert property (state_q[0] == 2'd2 |=> state_q[0] == 2'd2)
        else $error("error state left without reset");
    a_oc_hiz: assert property (oc_held |=> gate_oe_q[0] == 6'h00)
        else $error("gates not released on external overcurrent");
    a_oc_level: assert property (overcurrent_interrupt_q != 2'b00 |-> irq_level_q == 4'h0)
        else $error("overcurrent level wrong");
    a_conv_level: assert property (conv_done[0] |=> conversion_done_interrupt_q[0]
        && (irq_level_q == 4'h5 || overcurrent_interrupt_q != 2'b00)) else $error("conv level");
    a_tick_level: assert property (slow_tick_interrupt_q && conversion_done_interrupt_q == 2'b00
        && overcurrent_interrupt_q == 2'b00 |-> irq_level_q == 4'hA) else $error("tick level");
    a_no_shoot: assert property ((gate_q[0] & (gate_q[0] >> 1) & 6'h15) == 6'h00)
        else $error("both switches of a phase on");
    a_dead_gap: assert property ($rose(gate_q[0][1]) |-> hi_off_q >= 8'd250)
        else $error("dead time too short");
    a_tick_period: assert property (slow_tick_interrupt_q == (tick_gap_q == 16'd62500))
        else $error("slow tick period wrong");
    a_irq_any: assert property (irq_q == (overcurrent_interrupt_q != 2'b00
        || conversion_done_interrupt_q != 2'b00 || slow_tick_interrupt_q))
        else $error("interrupt flag does not match sources");
    a_oc_raise: assert property (oc_drop |-> ##4 overcurrent_interrupt_q[0])
        else $error("overcurrent interrupt missed");
endmodule : dmp_top_asserts

//--- tb/dmp_inverter_model.sv
// Purpose: Inverter power stage with current sensing for one channel.
// Assumes: A conversion ends every PERIOD cycles, shorter than a carrier period.
// Notes:   Outside the conversion cycle cur_w shows cur_set and the other samples are inverted, as a stale bus would be.
`timescale 1ns/1ps
module dmp_inverter_model #(
    parameter int PERIOD = 40
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        oc_trip,
    input  wire logic [11:0] cur_set,
    input  wire logic [11:0] vbus_set,
    input  wire logic [15:0] speed_set,
    output logic             conv_done,
    output logic      [11:0] cur_u,
    output logic      [11:0] cur_v,
    output logic      [11:0] cur_w,
    output logic      [11:0] vbus,
    output logic      [15:0] speed,
    output logic             ext_oc_n
);
    int cnt_q;
    always_ff @(posedge clk) begin
        cnt_q <= (srst || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    end
    assign conv_done = (cnt_q == PERIOD - 1);
    // Phase w mirrors phase u so that the three currents sum to zero.
    assign cur_u = conv_done ? cur_set : ~cur_set;
    assign cur_v = conv_done ? 12'h0800 : 12'h07FF;
    assign cur_w = conv_done ? 12'h0000 - cur_set : cur_set;
    assign vbus = conv_done ? vbus_set : ~vbus_set;
    assign speed = conv_done ? speed_set : ~speed_set;
    assign ext_oc_n = ~oc_trip;
endmodule : dmp_inverter_model

//--- tb/dual_motor_drive_protection_test.sv
// Purpose: Self-checking bench for the dual motor drive protection block.
// Assumes: Inverter models finish a conversion every 40 cycles.
// Notes:   Expected fault words are queued by the driver and checked by the monitor.
`timescale 1ns/1ps
module dual_motor_drive_protection_test;
    logic        clk = 1'b0;
    logic        srst, run1, run2;
    logic [1:0]  oc, ocint, state_q [2];
    logic [11:0] cur_set [2], vbus_set [2], duty_u [2], duty_v [2], duty_w [2];
    logic [15:0] spd_set [2];
    wire  [1:0]  conv_done, ext_n;
    wire  [11:0] cur_u [2], cur_v [2], cur_w [2], vbus [2];
    wire  [15:0] speed [2];
    logic [5:0]  gate_q [2], gate_oe_q [2];
    logic [3:0]  fault_q [2], last_fault [2], irq_level_q;
    logic [4:0]  exp_q [$];
    int          fail_count = 0;
    int          num_checks = 0;
    for (genvar c = 0; c < 2; c++) begin : g_inv
        dmp_inverter_model u_dmp_inverter_model (.clk(clk), .srst(srst), .oc_trip(oc[c]),
            .cur_set(cur_set[c]), .vbus_set(vbus_set[c]), .speed_set(spd_set[c]),
            .conv_done(conv_done[c]), .cur_u(cur_u[c]), .cur_v(cur_v[c]), .cur_w(cur_w[c]),
            .vbus(vbus[c]), .speed(speed[c]), .ext_oc_n(ext_n[c]));
    end
    dmp_top u_dmp_top (.clk(clk), .srst(srst), .motor1_run_switch(run1),
        .motor2_run_switch(run2), .ext_oc1_n(ext_n[0]), .ext_oc2_n(ext_n[1]),
        .conv_done(conv_done), .cur_u(cur_u), .cur_v(cur_v), .cur_w(cur_w), .vbus(vbus),
        .speed(speed), .duty_u(duty_u), .duty_v(duty_v), .duty_w(duty_w), .gate_q(gate_q),
        .gate_oe_q(gate_oe_q), .state_q(state_q), .fault_q(fault_q),
        .overcurrent_interrupt_q(ocint), .conversion_done_interrupt_q(),
        .slow_tick_interrupt_q(), .irq_q(), .irq_level_q(irq_level_q));
    always #4 clk = ~clk;
    task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
        num_checks++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("mismatch %s expected %h seen %h", what, exp, got);
    endtask : chk
    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // Reset with fresh legal samples; stale inverted samples may still break limits.
    task automatic restart(logic r);
        srst <= 1'b1;
        run1 <= 1'b0;
        run2 <= 1'b0;
        oc <= 2'b00;
        for (int c = 0; c < 2; c++) begin
            cur_set[c] <= 12'($urandom_range(12'h0490, 12'h0B70));
            vbus_set[c] <= 12'($urandom_range(12'h01BF, 12'h0D1B));
            spd_set[c] <= 16'($urandom_range(0, 16'h1194));
            duty_u[c] <= 12'($urandom_range(0, 3124));
            duty_v[c] <= 12'($urandom_range(0, 3124));
            duty_w[c] <= 12'($urandom_range(0, 3124));
        end
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        run1 <= r;
        run2 <= r;
        repeat (8) @(posedge clk);
    endtask : restart
    always @(posedge clk) begin : monitor
        logic [4:0] e;
        for (int c = 0; c < 2; c++) begin
            if (!srst && fault_q[c] !== last_fault[c] && fault_q[c] !== 4'h0) begin
                e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h00;
                chk("fault", {7'h00, e}, {7'h00, c[0], fault_q[c]});
                chk("trip", 12'h080, {4'h0, state_q[c], gate_q[c]});
            end
            last_fault[c] = fault_q[c];
        end
    end
    initial begin
        void'($urandom(10));
        restart(1'b0);
        chk("reset", 12'h00F, {4'h0, state_q[0], state_q[1], irq_level_q});
        restart(1'b1);
        chk("run", 12'h005, {8'h00, state_q[0], state_q[1]});
        repeat (64000) @(posedge clk);
        oc <= 2'b01;
        repeat (6) @(posedge clk);
        chk("oc_irq", 12'h010, {6'h00, ocint, irq_level_q});
        repeat (4) @(posedge clk);
        chk("oe_hiz", 12'h03F, {gate_oe_q[0], gate_oe_q[1]});
        oc <= 2'b00;
        repeat (10) @(posedge clk);
        chk("oe_back", 12'hFFF, {gate_oe_q[0], gate_oe_q[1]});
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < 2; c++) begin
                restart(1'b1);
                cur_set[c] <= 12'h0B70;
                vbus_set[c] <= (k == 2) ? 12'h01BF : 12'h0D1B;
                spd_set[c] <= 16'h1194;
                repeat (90) @(posedge clk);
                exp_q.push_back({c[0], 4'(1 << k)});
                case (k)
                    0: cur_set[c] <= 12'h0B71;
                    1: vbus_set[c] <= 12'h0D1C;
                    2: vbus_set[c] <= 12'h01BE;
                    default: spd_set[c] <= 16'h1195;
                endcase
                repeat (90) @(posedge clk);
                run1 <= 1'b0;
                run2 <= 1'b0;
                repeat (10) @(posedge clk);
                chk("state", c ? 12'h002 : 12'h008, {8'h00, state_q[0], state_q[1]});
            end
        end
        chk("pending", 12'h000, 12'(exp_q.size()));
        wrap_up();
    end
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
endmodule : dual_motor_drive_protection_test
bind dmp_top dmp_top_asserts u_dmp_top_asserts (.clk(clk), .srst(srst), .ext_oc1_n(ext_oc1_n),
    .conv_done(conv_done), .cur_u(cur_u), .vbus(vbus), .speed(speed), .gate_q(gate_q),
    .gate_oe_q(gate_oe_q), .state_q(state_q), .fault_q(fault_q),
    .overcurrent_interrupt_q(overcurrent_interrupt_q), .irq_level_q(irq_level_q),
    .conversion_done_interrupt_q(conversion_done_interrupt_q),
    .slow_tick_interrupt_q(slow_tick_interrupt_q), .irq_q(irq_q));
